//--- logic/pmbus_pad_status_telemetry_map.vh
// Command codes, field positions, reset values and timing for the status bank
`ifndef PMBUS_PAD_STATUS_TELEMETRY_MAP_VH
`define PMBUS_PAD_STATUS_TELEMETRY_MAP_VH

// Command codes
`define CMD_INPUT_VOLTAGE_READING   8'h88
`define CMD_INPUT_CURRENT_READING   8'h89
`define CMD_OUTPUT_VOLTAGE_READING  8'h8B
`define CMD_OUTPUT_CURRENT_READING  8'h8C
`define CMD_EXT_TEMP_READING        8'h8D
`define CMD_INT_TEMP_READING        8'h8E
`define CMD_OUTPUT_POWER_READING    8'h96
`define CMD_INPUT_POWER_READING     8'h97
`define CMD_OUTPUT_CURRENT_FINE     8'hBB
`define CMD_INPUT_CURRENT_MAXIMUM   8'hC4
`define CMD_INPUT_CURRENT_MINIMUM   8'hC5
`define CMD_INPUT_POWER_MAXIMUM     8'hC6
`define CMD_INPUT_POWER_MINIMUM     8'hC7
`define CMD_OUTPUT_CURRENT_MAXIMUM  8'hD7
`define CMD_OUTPUT_CURRENT_MINIMUM  8'hD8
`define CMD_OUTPUT_VOLTAGE_MAXIMUM  8'hDD
`define CMD_INPUT_VOLTAGE_MAXIMUM   8'hDE
`define CMD_EXT_TEMP_MAXIMUM        8'hDF
`define CMD_CURRENT_SENSE_VOLTAGE   8'hFA
`define CMD_OUTPUT_VOLTAGE_MINIMUM  8'hFB
`define CMD_INPUT_VOLTAGE_MINIMUM   8'hFC
`define CMD_EXT_TEMP_MINIMUM        8'hFD
`define CMD_PAD_LEVEL_SNAPSHOT      8'hE5
`define CMD_COMMON_DEVICE_STATUS    8'hEF

// Common status fields
`define COMMON_ALERT_BIT            7
`define COMMON_READY_BIT            6
`define COMMON_RESERVED_VALUE       4'hF
`define COMMON_SHARE_CLK_BIT        1
`define COMMON_WRITE_PROTECT_BIT    0

// Pad snapshot fields
`define PAD_POWER_GOOD_BIT          15
`define PAD_ALERT_BIT               14
`define PAD_RESERVED_VALUE          2'h0

// Record reset values
`define L11_MOST_NEGATIVE           16'h7C00
`define L11_MOST_POSITIVE           16'h7BFF
`define L16_RECORD_MAX_RESET        16'hF800
`define L16_RECORD_MIN_RESET        16'hFFFF
`define READ_DATA_RESET             16'h0000

// Timing
`define CLK_PERIOD_NS               20
`define SHARE_CLK_IDLE_NS           10000
`define SHARE_CLK_IDLE_CYC          10'h1F4

`endif

//--- logic/pmbus_pad_status_telemetry.v
// Status, pad snapshot and telemetry read bank behind the PMBus command port
//
// Operation
// - Pad snapshot is read-only; bits 15:12 show drive states, bits 9:0 synchronised pad levels.
// - Bit 15 low while power-good driven low; bit 14 same for alert.
// - Bits 13:12 show fault pad 0/1 drive, 0 when pulled low.
// - Bits 9:8 and 7:6 carry address-select pad 1 and 0 codes.
// - Control pads on bits 4,5,1,0 for controls 0,1,2,3; high reads 1.
// - Bits 3:2 show sensed levels of fault pads 0 and 1.
// - Only common status is accepted and answered while busy.
// - Busy device acks address, NACKs command, sets byte and word busy flags.
// - A busy rejection also asserts the active-low alert output.
// - Common bit 7 mirrors alert; 1 released, 0 asserted.
// - Common bit 6 is 1 when ready, 0 while busy.
// - Common bits 5:2 are reserved and read ones.
// - Common bit 1 is 1 while share clock held low, 0 when toggling.
// - Common bit 0 reflects write-protect pin level.
// - Unpaged input voltage, current, power reads in L11.
// - Paged output voltage L16, output current and power L11.
// - Paged external and unpaged internal temperature reads in L11.
// - Paged fine output current read, 2.5 mA per count.
// - Paged sense voltage read, absolute value, 3.05 uV per count.
// - Unpaged input max and min records in L11.
// - Paged output voltage, current, temperature max and min records.
// - Input maximums reload most negative code on reset, clear, turn-on.
// - Input minimums reload largest positive code on reset, clear, turn-on.
`timescale 1ns/10ps
`include "pmbus_pad_status_telemetry_map.vh"

// ---------------------------------------------
// Peak and valley tracker for one quantity
// ---------------------------------------------
module minmax_record #(
  parameter [15:0] MAX_RESET = `L11_MOST_NEGATIVE,
  parameter [15:0] MIN_RESET = `L11_MOST_POSITIVE,
  parameter        IS_L16    = 0
) (
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire        i_reload,
  input  wire        i_update,
  input  wire [15:0] i_value,
  output reg  [15:0] o_max,
  output reg  [15:0] o_min
);

  // L11 words are mantissa times two to the exponent; L16 is unsigned
  function signed [47:0] order_key;
    input [15:0] w;
    reg [5:0] sh;
    reg signed [47:0] m;
    begin
      sh = {w[15], w[15:11]} + 6'h10;
      m  = {{37{w[10]}}, w[10:0]};
      if (IS_L16 != 0)
        order_key = {32'h0, w};
      else
        order_key = m <<< sh;
    end
  endfunction

  // Reload outranks a sample arriving in the same cycle
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_max <= MAX_RESET;
      o_min <= MIN_RESET;
    end
    else if (i_reload)
    begin
      o_max <= MAX_RESET;
      o_min <= MIN_RESET;
    end
    else if (i_update)
    begin
      if (order_key(i_value) > order_key(o_max))
        o_max <= i_value;
      if (order_key(i_value) < order_key(o_min))
        o_min <= i_value;
    end
  end

endmodule // minmax_record

// ---------------------------------------------
// Top of the bank
// ---------------------------------------------
module pmbus_pad_status_telemetry (
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire        i_addr_match,
  input  wire        i_cmd_strobe,
  input  wire [7:0]  i_cmd_code,
  input  wire [1:0]  i_page,
  input  wire        i_busy,
  input  wire        i_clear_faults,
  input  wire        i_busy_flag_clear,
  input  wire        i_alert_request,
  input  wire [3:0]  i_channel_on,
  input  wire        i_pwrgd_drive_low,
  input  wire [1:0]  i_fault_drive_low,
  input  wire        i_fault_share_pad_0,
  input  wire        i_fault_share_pad_1,
  input  wire [1:0]  i_address_select_pad_0,
  input  wire [1:0]  i_address_select_pad_1,
  input  wire        i_channel_control_pad_0,
  input  wire        i_channel_control_pad_1,
  input  wire        i_channel_control_pad_2,
  input  wire        i_channel_control_pad_3,
  input  wire        i_share_clk_pin,
  input  wire        i_write_protect_pin,
  input  wire        i_meas_strobe,
  input  wire [15:0] i_vin,
  input  wire [15:0] i_iin,
  input  wire [15:0] i_pin,
  input  wire [15:0] i_temp_int,
  input  wire [63:0] i_vout_all,
  input  wire [63:0] i_iout_all,
  input  wire [63:0] i_pout_all,
  input  wire [63:0] i_temp_ext_all,
  input  wire [63:0] i_iout_fine_all,
  input  wire [63:0] i_sense_v_all,
  output reg         o_addr_ack,
  output reg         o_cmd_ack,
  output reg         o_cmd_nack,
  output reg  [15:0] o_rd_data,
  output reg         o_status_byte_busy,
  output reg         o_status_word_busy,
  output wire        o_alert_out,
  output wire        o_alert_oe
);

  // ---------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------
  wire [11:0] pin_raw;
  reg  [11:0] pin_meta_reg;
  reg  [11:0] pin_sync_reg;

  assign pin_raw = {i_write_protect_pin, i_share_clk_pin,
                    i_address_select_pad_1, i_address_select_pad_0,
                    i_fault_share_pad_1, i_fault_share_pad_0,
                    i_channel_control_pad_3, i_channel_control_pad_2,
                    i_channel_control_pad_1, i_channel_control_pad_0};

  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_meta_reg <= 12'h000;
      pin_sync_reg <= 12'h000;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire [3:0] ctl_lvl   = pin_sync_reg[3:0];
  wire       fault0_lv = pin_sync_reg[4];
  wire       fault1_lv = pin_sync_reg[5];
  wire [1:0] address_select_pad_0     = pin_sync_reg[7:6];
  wire [1:0] address_select_pad_1     = pin_sync_reg[9:8];
  wire       share_lv  = pin_sync_reg[10];
  wire       wp_lv     = pin_sync_reg[11];

  // ---------------------------------------------
  // Share clock activity
  // ---------------------------------------------
  // Idle count starts full so a quiet low pin reads held from reset on
  reg        share_prev_reg;
  reg [9:0]  share_idle_reg;
  reg        share_held_reg;
  wire       share_edge = share_lv ^ share_prev_reg;

  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      share_prev_reg <= 1'b0;
      share_idle_reg <= `SHARE_CLK_IDLE_CYC;
      share_held_reg <= 1'b1;
    end
    else
    begin
      share_prev_reg <= share_lv;
      if (share_edge)
        share_idle_reg <= 10'h000;
      else if (share_idle_reg != `SHARE_CLK_IDLE_CYC)
        share_idle_reg <= share_idle_reg + 10'h001;
      share_held_reg <= !share_lv &&
                        (share_idle_reg == `SHARE_CLK_IDLE_CYC);
    end
  end

  // ---------------------------------------------
  // Alert drive
  // ---------------------------------------------
  reg  busy_alert_reg;
  wire busy_reject;

  assign o_alert_oe  = busy_alert_reg | i_alert_request;
  assign o_alert_out = 1'b0;

  // ---------------------------------------------
  // Pad snapshot and common status
  // ---------------------------------------------
  wire [15:0] pad_snapshot;
  wire [7:0]  common_status;

  assign pad_snapshot = {!i_pwrgd_drive_low,
                         !o_alert_oe,
                         !i_fault_drive_low[0],
                         !i_fault_drive_low[1],
                         `PAD_RESERVED_VALUE,
                         address_select_pad_1,
                         address_select_pad_0,
                         ctl_lvl[1], ctl_lvl[0],
                         fault0_lv, fault1_lv,
                         ctl_lvl[2], ctl_lvl[3]};

  assign common_status = {!o_alert_oe,
                          !i_busy,
                          `COMMON_RESERVED_VALUE,
                          share_held_reg,
                          wp_lv};

  // ---------------------------------------------
  // Records
  // ---------------------------------------------
  reg  [3:0] chan_on_prev_reg;
  wire [3:0] chan_turn_on = i_channel_on & ~chan_on_prev_reg;
  wire       in_reload    = i_clear_faults | (|chan_turn_on);

  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      chan_on_prev_reg <= 4'h0;
    else
      chan_on_prev_reg <= i_channel_on;
  end

  wire [15:0] iin_max, iin_min, pin_max, pin_min, vin_max, vin_min;

  minmax_record u_iin_rec (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_reload  (in_reload),
    .i_update  (i_meas_strobe),
    .i_value   (i_iin),
    .o_max     (iin_max),
    .o_min     (iin_min)
  );

  minmax_record u_pin_rec (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_reload  (in_reload),
    .i_update  (i_meas_strobe),
    .i_value   (i_pin),
    .o_max     (pin_max),
    .o_min     (pin_min)
  );

  minmax_record u_vin_rec (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_reload  (in_reload),
    .i_update  (i_meas_strobe),
    .i_value   (i_vin),
    .o_max     (vin_max),
    .o_min     (vin_min)
  );

  wire [63:0] vout_max_all, vout_min_all;
  wire [63:0] iout_max_all, iout_min_all;
  wire [63:0] temp_max_all, temp_min_all;

  // Clear reaches every channel's records; only a channel's own turn-on does
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_chan
      wire ch_reload = i_clear_faults | chan_turn_on[ch];

      minmax_record #(
        .MAX_RESET (`L16_RECORD_MAX_RESET),
        .MIN_RESET (`L16_RECORD_MIN_RESET),
        .IS_L16    (1)
      ) u_vout_rec (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_reload  (ch_reload),
        .i_update  (i_meas_strobe),
        .i_value   (i_vout_all[ch*16 +: 16]),
        .o_max     (vout_max_all[ch*16 +: 16]),
        .o_min     (vout_min_all[ch*16 +: 16])
      );

      minmax_record u_iout_rec (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_reload  (ch_reload),
        .i_update  (i_meas_strobe),
        .i_value   (i_iout_all[ch*16 +: 16]),
        .o_max     (iout_max_all[ch*16 +: 16]),
        .o_min     (iout_min_all[ch*16 +: 16])
      );

      minmax_record u_temp_rec (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_reload  (ch_reload),
        .i_update  (i_meas_strobe),
        .i_value   (i_temp_ext_all[ch*16 +: 16]),
        .o_max     (temp_max_all[ch*16 +: 16]),
        .o_min     (temp_min_all[ch*16 +: 16])
      );
    end
  endgenerate

  // ---------------------------------------------
  // Command decode
  // ---------------------------------------------
  reg [15:0] sel_data;
  reg        sel_known;

  always @*
  begin
    sel_known = 1'b1;
    case (i_cmd_code)
      `CMD_INPUT_VOLTAGE_READING:  sel_data = i_vin;
      `CMD_INPUT_CURRENT_READING:  sel_data = i_iin;
      `CMD_INPUT_POWER_READING:    sel_data = i_pin;
      `CMD_OUTPUT_VOLTAGE_READING:
        sel_data = i_vout_all[i_page*16 +: 16];
      `CMD_OUTPUT_CURRENT_READING:
        sel_data = i_iout_all[i_page*16 +: 16];
      `CMD_OUTPUT_POWER_READING:
        sel_data = i_pout_all[i_page*16 +: 16];
      `CMD_EXT_TEMP_READING:
        sel_data = i_temp_ext_all[i_page*16 +: 16];
      `CMD_INT_TEMP_READING:       sel_data = i_temp_int;
      `CMD_OUTPUT_CURRENT_FINE:
        sel_data = i_iout_fine_all[i_page*16 +: 16];
      `CMD_CURRENT_SENSE_VOLTAGE:
        sel_data = i_sense_v_all[i_page*16 +: 16];
      `CMD_INPUT_CURRENT_MAXIMUM:  sel_data = iin_max;
      `CMD_INPUT_CURRENT_MINIMUM:  sel_data = iin_min;
      `CMD_INPUT_POWER_MAXIMUM:    sel_data = pin_max;
      `CMD_INPUT_POWER_MINIMUM:    sel_data = pin_min;
      `CMD_INPUT_VOLTAGE_MAXIMUM:  sel_data = vin_max;
      `CMD_INPUT_VOLTAGE_MINIMUM:  sel_data = vin_min;
      `CMD_OUTPUT_VOLTAGE_MAXIMUM:
        sel_data = vout_max_all[i_page*16 +: 16];
      `CMD_OUTPUT_VOLTAGE_MINIMUM:
        sel_data = vout_min_all[i_page*16 +: 16];
      `CMD_OUTPUT_CURRENT_MAXIMUM:
        sel_data = iout_max_all[i_page*16 +: 16];
      `CMD_OUTPUT_CURRENT_MINIMUM:
        sel_data = iout_min_all[i_page*16 +: 16];
      `CMD_EXT_TEMP_MAXIMUM:
        sel_data = temp_max_all[i_page*16 +: 16];
      `CMD_EXT_TEMP_MINIMUM:
        sel_data = temp_min_all[i_page*16 +: 16];
      `CMD_PAD_LEVEL_SNAPSHOT:     sel_data = pad_snapshot;
      `CMD_COMMON_DEVICE_STATUS:   sel_data = {8'h00, common_status};
      default:
      begin
        sel_data  = `READ_DATA_RESET;
        sel_known = 1'b0;
      end
    endcase
  end

  // Common status stays reachable so the host can poll for ready
  wire is_common = (i_cmd_code == `CMD_COMMON_DEVICE_STATUS);
  wire cmd_ok    = i_cmd_strobe && sel_known &&
                   (!i_busy || is_common);
  assign busy_reject = i_cmd_strobe && i_busy && !is_common;

  // ---------------------------------------------
  // Answer and flags
  // ---------------------------------------------
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_addr_ack         <= 1'b0;
      o_cmd_ack          <= 1'b0;
      o_cmd_nack         <= 1'b0;
      o_rd_data          <= `READ_DATA_RESET;
      o_status_byte_busy <= 1'b0;
      o_status_word_busy <= 1'b0;
      busy_alert_reg     <= 1'b0;
    end
    else
    begin
      o_addr_ack <= i_addr_match;
      o_cmd_ack  <= cmd_ok;
      o_cmd_nack <= i_cmd_strobe && !cmd_ok;
      if (cmd_ok)
        o_rd_data <= sel_data;
      // A rejection in the clearing cycle still leaves the flags set
      if (busy_reject)
      begin
        o_status_byte_busy <= 1'b1;
        o_status_word_busy <= 1'b1;
        busy_alert_reg     <= 1'b1;
      end
      else if (i_busy_flag_clear || i_clear_faults)
      begin
        o_status_byte_busy <= 1'b0;
        o_status_word_busy <= 1'b0;
        busy_alert_reg     <= 1'b0;
      end
    end
  end

endmodule // pmbus_pad_status_telemetry

//--- tb/pmbus_pad_status_telemetry_assertions.sv
// Concurrent checks on the ports of the status and telemetry bank
`timescale 1ns/10ps
module pmbus_pad_status_telemetry_assertions (
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire        i_addr_match,
  input  wire        i_cmd_strobe,
  input  wire [7:0]  i_cmd_code,
  input  wire        i_busy,
  input  wire        i_clear_faults,
  input  wire        i_busy_flag_clear,
  input  wire        i_alert_request,
  input  wire        i_pwrgd_drive_low,
  input  wire [1:0]  i_fault_drive_low,
  input  wire [15:0] i_vin,
  input  wire        o_addr_ack,
  input  wire        o_cmd_ack,
  input  wire        o_cmd_nack,
  input  wire [15:0] o_rd_data,
  input  wire        o_status_byte_busy,
  input  wire        o_status_word_busy,
  input  wire        o_alert_oe
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // Calm means the alert register cannot move on this edge
  wire rej  = i_cmd_strobe && i_busy && (i_cmd_code != 8'hEF);
  wire calm = !i_busy && !i_clear_faults && !i_busy_flag_clear;

  addr_ack_a: assert property (i_addr_match |=> o_addr_ack)
    else $error("own address not acknowledged");
  busy_nack_a: assert property (rej |=> o_cmd_nack && !o_cmd_ack
    && o_status_byte_busy && o_status_word_busy) else $error("busy command not refused");
  busy_alert_a: assert property (rej |=> o_alert_oe)
    else $error("alert not driven on busy refusal");
  common_ack_a: assert property (i_cmd_strobe && i_cmd_code == 8'hEF |=> o_cmd_ack
    && o_rd_data[15:8] == 8'h00 && o_rd_data[5:2] == 4'hF) else $error("common status bad");
  common_ready_a: assert property (i_cmd_strobe && i_cmd_code == 8'hEF
    |=> o_rd_data[6] == !$past(i_busy)) else $error("ready bit wrong");
  alert_mirror_a: assert property (i_cmd_strobe && i_cmd_code == 8'hEF && calm
    ##1 $stable(i_alert_request) |-> o_rd_data[7] == !o_alert_oe) else $error("alert bit wrong");
  pad_drive_a: assert property (i_cmd_strobe && i_cmd_code == 8'hE5 && calm
    ##1 $stable(i_alert_request) |-> o_rd_data[15] == !$past(i_pwrgd_drive_low)
    && o_rd_data[14] == !o_alert_oe && o_rd_data[11:10] == 2'b00
    && o_rd_data[13:12] == ~{$past(i_fault_drive_low[0]), $past(i_fault_drive_low[1])})
    else $error("pad drive bits wrong");
  flag_hold_a: assert property (o_status_byte_busy && !i_clear_faults
    && !i_busy_flag_clear |=> o_status_byte_busy && o_status_word_busy)
    else $error("busy flag dropped");
  one_answer_a: assert property (i_cmd_strobe |=> o_cmd_ack != o_cmd_nack)
    else $error("command not answered once");
  vin_read_a: assert property (i_cmd_strobe && !i_busy && i_cmd_code == 8'h88
    |=> o_cmd_ack && o_rd_data == $past(i_vin)) else $error("input voltage read wrong");
endmodule // pmbus_pad_status_telemetry_assertions

bind pmbus_pad_status_telemetry pmbus_pad_status_telemetry_assertions u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr_match(i_addr_match),
  .i_cmd_strobe(i_cmd_strobe), .i_cmd_code(i_cmd_code), .i_busy(i_busy),
  .i_clear_faults(i_clear_faults), .i_busy_flag_clear(i_busy_flag_clear),
  .i_alert_request(i_alert_request), .i_pwrgd_drive_low(i_pwrgd_drive_low),
  .i_fault_drive_low(i_fault_drive_low), .i_vin(i_vin), .o_addr_ack(o_addr_ack),
  .o_cmd_ack(o_cmd_ack), .o_cmd_nack(o_cmd_nack), .o_rd_data(o_rd_data),
  .o_status_byte_busy(o_status_byte_busy), .o_status_word_busy(o_status_word_busy),
  .o_alert_oe(o_alert_oe));

//--- tb/pmbus_host_model.sv
// Behavioural PMBus host issuing command reads to the bank
`timescale 1ns/10ps
module pmbus_host_model (
  input  wire        i_ref_clk,
  input  wire        i_addr_ack,
  input  wire        i_cmd_ack,
  input  wire        i_cmd_nack,
  input  wire [15:0] i_rd_data,
  output reg         o_addr_match,
  output reg         o_cmd_strobe,
  output reg  [7:0]  o_cmd_code,
  output reg  [1:0]  o_page
);
  initial
  begin
    o_addr_match = 1'b0;
    o_cmd_strobe = 1'b0;
    o_cmd_code   = 8'h00;
    o_page       = 2'h0;
  end

  task read_word(input [7:0] cd, input [1:0] p, output [15:0] d, output aa, a, n);
    begin
      @(negedge i_ref_clk) o_addr_match = 1'b1;
      @(negedge i_ref_clk) aa = i_addr_ack;
      o_addr_match = 1'b0;
      o_cmd_strobe = 1'b1;
      o_cmd_code = cd;
      o_page = p;
      @(negedge i_ref_clk) a = i_cmd_ack;
      n = i_cmd_nack;
      d = i_rd_data;
      o_cmd_strobe = 1'b0;
      // Released lines show the inverse so a stale code never matches
      o_cmd_code = ~cd;
      o_page = ~p;
    end
  endtask

  task poll_ready(output reg ok);
    reg [15:0] d;
    reg        aa, a, n;
    integer    t;
    begin
      ok = 1'b0;
      for (t = 0; t < 40 && !ok; t = t + 1)
      begin
        read_word(8'hEF, 2'h0, d, aa, a, n);
        ok = a && d[6];
      end
    end
  endtask
endmodule // pmbus_host_model

//--- tb/pmbus_pad_status_telemetry_tb.sv
// Self-checking bench for the status and telemetry bank with a reference model
`timescale 1ns/10ps
module pmbus_pad_status_telemetry_tb;
  reg         i_ref_clk, i_rst_n, busy, clr, bclr, areq, meas, pgd_low, shclk, wp;
  reg         m_alert, exp_sh, ok;
  reg  [3:0]  chon, ctl;
  reg  [1:0]  fdl, fpad, address_select_pad_0, address_select_pad_1, pg;
  reg  [15:0] vin, iin, pin, tint;
  reg  [63:0] vout, iout, pout, text, fine, sense;
  wire        amatch, strobe, aack, ack, nack, sbb, swb, aout, aoe;
  wire [7:0]  code;
  wire [1:0]  page;
  wire [15:0] rdata;
  reg  [15:0] rmax [0:5][0:3];
  reg  [15:0] rmin [0:5][0:3];
  integer     num_errors, checks_done, q, c, k;

  pmbus_pad_status_telemetry dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr_match(amatch), .i_cmd_strobe(strobe),
    .i_cmd_code(code), .i_page(page), .i_busy(busy), .i_clear_faults(clr),
    .i_busy_flag_clear(bclr), .i_alert_request(areq), .i_channel_on(chon),
    .i_pwrgd_drive_low(pgd_low), .i_fault_drive_low(fdl), .i_fault_share_pad_0(fpad[0]),
    .i_fault_share_pad_1(fpad[1]), .i_address_select_pad_0(address_select_pad_0),
    .i_address_select_pad_1(address_select_pad_1), .i_channel_control_pad_0(ctl[0]),
    .i_channel_control_pad_1(ctl[1]), .i_channel_control_pad_2(ctl[2]),
    .i_channel_control_pad_3(ctl[3]), .i_share_clk_pin(shclk), .i_write_protect_pin(wp),
    .i_meas_strobe(meas), .i_vin(vin), .i_iin(iin), .i_pin(pin), .i_temp_int(tint),
    .i_vout_all(vout), .i_iout_all(iout), .i_pout_all(pout), .i_temp_ext_all(text),
    .i_iout_fine_all(fine), .i_sense_v_all(sense), .o_addr_ack(aack), .o_cmd_ack(ack),
    .o_cmd_nack(nack), .o_rd_data(rdata), .o_status_byte_busy(sbb),
    .o_status_word_busy(swb), .o_alert_out(aout), .o_alert_oe(aoe));

  pmbus_host_model u_host (
    .i_ref_clk(i_ref_clk), .i_addr_ack(aack), .i_cmd_ack(ack), .i_cmd_nack(nack),
    .i_rd_data(rdata), .o_addr_match(amatch), .o_cmd_strobe(strobe), .o_cmd_code(code),
    .o_page(page));

  // --------------------
  // Reference model
  // --------------------
  function real l11(input [15:0] w);
    l11 = $signed(w[10:0]) * (2.0 ** $signed(w[15:11]));
  endfunction

  function [15:0] qv(input integer qq, input integer cc);
    case (qq)
      0: qv = iin;
      1: qv = pin;
      2: qv = vin;
      3: qv = vout[16*cc+:16];
      4: qv = iout[16*cc+:16];
      default: qv = text[16*cc+:16];
    endcase
  endfunction

  function [16:0] expw(input [7:0] cd, input integer p);
    reg a;
    begin
      a = m_alert | areq;
      case (cd)
        8'h88: expw = {1'b1, vin};
        8'h89: expw = {1'b1, iin};
        8'h97: expw = {1'b1, pin};
        8'h8E: expw = {1'b1, tint};
        8'h8B: expw = {1'b1, vout[16*p+:16]};
        8'h8C: expw = {1'b1, iout[16*p+:16]};
        8'h96: expw = {1'b1, pout[16*p+:16]};
        8'h8D: expw = {1'b1, text[16*p+:16]};
        8'hBB: expw = {1'b1, fine[16*p+:16]};
        8'hFA: expw = {1'b1, sense[16*p+:16]};
        8'hC4: expw = {1'b1, rmax[0][0]};
        8'hC5: expw = {1'b1, rmin[0][0]};
        8'hC6: expw = {1'b1, rmax[1][0]};
        8'hC7: expw = {1'b1, rmin[1][0]};
        8'hDE: expw = {1'b1, rmax[2][0]};
        8'hFC: expw = {1'b1, rmin[2][0]};
        8'hDD: expw = {1'b1, rmax[3][p]};
        8'hFB: expw = {1'b1, rmin[3][p]};
        8'hD7: expw = {1'b1, rmax[4][p]};
        8'hD8: expw = {1'b1, rmin[4][p]};
        8'hDF: expw = {1'b1, rmax[5][p]};
        8'hFD: expw = {1'b1, rmin[5][p]};
        8'hE5: expw = {1'b1, ~pgd_low, ~a, ~fdl[0], ~fdl[1], 2'b00, address_select_pad_1, address_select_pad_0,
                       ctl[1], ctl[0], fpad[0], fpad[1], ctl[2], ctl[3]};
        8'hEF: expw = {9'h100, ~a, ~busy, 4'hF, exp_sh, wp};
        default: expw = 17'h00000;
      endcase
    end
  endfunction

  task reload_set(input integer ch);
    for (q = 0; q < 6; q = q + 1)
      for (c = 0; c < 4; c = c + 1)
        if (ch < 0 || q < 3 || c == ch)
        begin
          rmax[q][c] = (q == 3) ? 16'hF800 : 16'h7C00;
          rmin[q][c] = (q == 3) ? 16'hFFFF : 16'h7BFF;
        end
  endtask

  // Exponent held at zero so two codes never tie on value
  task meas_tick;
    reg [15:0] v;
    begin
      vin = 16'($urandom) & 16'h07FF;
      iin = 16'($urandom) & 16'h07FF;
      pin = 16'($urandom) & 16'h07FF;
      tint = 16'($urandom);
      vout = {$urandom, $urandom};
      iout = {$urandom, $urandom} & 64'h07FF07FF07FF07FF;
      text = {$urandom, $urandom} & 64'h07FF07FF07FF07FF;
      pout = {$urandom, $urandom};
      fine = {$urandom, $urandom};
      sense = {$urandom, $urandom};
      @(negedge i_ref_clk) meas = 1'b1;
      @(negedge i_ref_clk) meas = 1'b0;
      for (q = 0; q < 6; q = q + 1)
        for (c = 0; c < 4; c = c + 1)
        begin
          v = qv(q, c);
          if (q == 3 ? v > rmax[q][c] : l11(v) > l11(rmax[q][c])) rmax[q][c] = v;
          if (q == 3 ? v < rmin[q][c] : l11(v) < l11(rmin[q][c])) rmin[q][c] = v;
        end
    end
  endtask

  // --------------------
  // Checking tasks
  // --------------------
  task chk(input [79:0] nm, input [15:0] s, input [15:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e)
      begin
        num_errors = num_errors + 1;
        $display("[ERR] %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  task rd(input [7:0] cd);
    reg [16:0] e;
    reg [15:0] d;
    reg        aa, a, n;
    begin
      pg = 2'($urandom);
      e = expw(cd, pg);
      u_host.read_word(cd, pg, d, aa, a, n);
      chk("addr_ack", aa, 1'b1);
      if (busy && cd != 8'hEF)
      begin
        m_alert = 1'b1;
        chk("busy_nack", {a, n}, 2'b01);
        chk("busy_flags", {sbb, swb}, 2'b11);
      end
      else if (!e[16])
        chk("nack", {a, n, sbb}, {2'b01, m_alert});
      else
      begin
        chk("ack", {a, n}, 2'b10);
        chk("word", d, e[15:0]);
      end
      chk("alert_oe", {aoe, aout}, {m_alert | areq, 1'b0});
    end
  endtask

  task sweep;
    integer cd;
    for (cd = 8'h80; cd < 9'h100; cd = cd + 1)
      rd(cd[7:0]);
  endtask

  task summarize;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // --------------------
  // Stimulus
  // --------------------
  initial
  begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  initial
  begin
    #400000;
    num_errors = num_errors + 1;
    summarize;
  end

  initial
  begin
    {i_rst_n, busy, clr, bclr, areq, meas, pgd_low, shclk, m_alert} = 9'h000;
    {wp, exp_sh, chon, ctl, fdl, fpad, address_select_pad_0, address_select_pad_1, pg} = 20'h40000;
    {vin, iin, pin, tint} = 64'h0;
    {vout, iout, pout, text, fine, sense} = 384'h0;
    num_errors = 0;
    checks_done = 0;
    k = $urandom(45246);
    reload_set(-1);
    repeat (4) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    sweep;
    repeat (4)
    begin
      meas_tick;
      sweep;
    end
    k = $urandom % 4;
    @(negedge i_ref_clk) chon[k] = 1'b1;
    @(negedge i_ref_clk) reload_set(k);
    sweep;
    meas_tick;
    sweep;
    @(negedge i_ref_clk) clr = 1'b1;
    @(negedge i_ref_clk) clr = 1'b0;
    reload_set(-1);
    chon = 4'h0;
    sweep;
    repeat (16)
    begin
      {pgd_low, fdl, fpad, ctl, wp, areq} = 11'($urandom);
      k = $urandom % 3;
      address_select_pad_0 = (k == 0) ? 2'b00 : 2'(k + 1);
      address_select_pad_1 = (k == 1) ? 2'b00 : 2'b11;
      repeat (3) @(negedge i_ref_clk);
      rd(8'hE5);
      rd(8'hEF);
    end
    areq = 1'b0;
    repeat (10) @(negedge i_ref_clk) shclk = ~shclk;
    exp_sh = 1'b0;
    rd(8'hEF);
    repeat (520) @(negedge i_ref_clk);
    exp_sh = 1'b1;
    rd(8'hEF);
    busy = 1'b1;
    rd(8'h8B);
    rd(8'h00);
    rd(8'hEF);
    rd(8'hE5);
    busy = 1'b0;
    u_host.poll_ready(ok);
    chk("ready", ok, 1'b1);
    @(negedge i_ref_clk) bclr = 1'b1;
    @(negedge i_ref_clk) bclr = 1'b0;
    m_alert = 1'b0;
    chk("flag_clr", {sbb, swb, aoe}, 3'b000);
    rd(8'hEF);
    summarize;
  end
endmodule // pmbus_pad_status_telemetry_tb
